// ===== design/latc_ctrl.v
`include "latc_regs.vh"

module latc_ctrl #(
  parameter LKP_AW = 12,
  parameter STA_AW = 4,
  parameter RMC_AW = 6,
  parameter CNT_W = 14
) (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire [15:0] reg_addr_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [3:0] reg_be_in,
  input wire [31:0] reg_wdata_in,
  output wire [31:0] reg_rdata_out,
  output wire reg_rvalid_out
);
  localparam S_IDLE = 7'h01;
  localparam S_WR = 7'h02;
  localparam S_RD = 7'h04;
  localparam S_RDL = 7'h08;
  localparam S_SCAN = 7'h10;
  localparam S_EVAL = 7'h20;
  localparam S_HOLD = 7'h40;

  localparam T_IDLE = 3'h1;
  localparam T_OP = 3'h2;
  localparam T_LD = 3'h4;

  function [31:0] be_merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] be;
    integer k;
    begin
      be_merge = old_v;
      for (k = 0; k < `LATC_LANES; k = k + 1) begin
        if (be[k]) begin
          be_merge[k*`LATC_LANE_W +: `LATC_LANE_W] =
            new_v[k*`LATC_LANE_W +: `LATC_LANE_W];
        end
      end
    end
  endfunction

  // Fold the key into a table location
  function [`LATC_HASH_W-1:0] key_hash;
    input [6:0] filt;
    input [47:0] mac;
    begin
      key_hash = mac[11:0] ^ mac[23:12] ^ mac[35:24] ^ mac[47:36] ^
        {`LATC_FILT_PAD, filt};
    end
  endfunction

  reg rsv31_q;
  reg [6:0] filter_id_q;
  reg [15:0] mach_q;
  reg [31:0] macl_q;
  reg go_q;
  reg [1:0] arsv_q;
  reg direct_q;
  reg [1:0] act_q;
  reg valid_q;
  reg search_end_q;
  reg [CNT_W-1:0] cnt_q;
  reg [LKP_AW-1:0] scan_idx_q;
  reg [6:0] st_q;
  reg [6:0] st_d;

  reg sgo_q;
  reg [5:0] tidx_q;
  reg [4:0] srsv_q;
  reg tsel_q;
  reg sop_q;
  reg [2:0] tst_q;
  reg [2:0] tst_d;

  reg [`LATC_ENT_W-1:0] ent_q;
  reg [`LATC_ENT_W-1:0] ent_d;
  reg [31:0] rdata_q;
  reg rvalid_q;
  reg [31:0] rd_mux;

  wire hit_ihi = reg_addr_in == `LATC_OFS_IDX_HI;
  wire hit_ilo = reg_addr_in == `LATC_OFS_IDX_LO;
  wire hit_actl = reg_addr_in == `LATC_OFS_LKP_CTL;
  wire hit_sctl = reg_addr_in == `LATC_OFS_STA_CTL;
  wire hit_e1 = reg_addr_in == `LATC_OFS_ENT1;
  wire hit_e2 = reg_addr_in == `LATC_OFS_ENT2;
  wire hit_e3 = reg_addr_in == `LATC_OFS_ENT3;
  wire hit_e4 = reg_addr_in == `LATC_OFS_ENT4;

  wire lkp_idle = st_q == S_IDLE;
  wire sta_idle = tst_q == T_IDLE;

  wire [31:0] ihi_now = {rsv31_q, 8'h00, filter_id_q, mach_q};
  wire [31:0] actl_now = {2'h0, cnt_q, 8'h00, go_q, valid_q,
    valid_q | search_end_q, arsv_q, direct_q, act_q};
  wire [31:0] sctl_now = {10'h000, tidx_q, 8'h00, sgo_q, srsv_q,
    tsel_q, sop_q};
  wire [31:0] ihi_w = be_merge(ihi_now, reg_wdata_in, reg_be_in);
  wire [31:0] ilo_w = be_merge(macl_q, reg_wdata_in, reg_be_in);
  wire [31:0] actl_w = be_merge(actl_now, reg_wdata_in, reg_be_in);
  wire [31:0] sctl_w = be_merge(sctl_now, reg_wdata_in, reg_be_in);

  // Control writes are ignored while that controller is busy
  wire wr_actl = reg_wr_in & hit_actl & lkp_idle;
  wire wr_sctl = reg_wr_in & hit_sctl & sta_idle;
  wire lkp_start = wr_actl & actl_w[`LATC_GO_BIT];
  wire [1:0] act_w = actl_w[`LATC_ACT_HI:`LATC_ACT_LO];
  wire sta_start = wr_sctl & sctl_w[`LATC_GO_BIT];
  wire top_read = reg_rd_in & hit_e4 & reg_be_in[`LATC_LANE_TOP];

  wire [47:0] mac_key = {mach_q, macl_q};
  wire [`LATC_HASH_W-1:0] hashed = key_hash(filter_id_q, mac_key);
  wire [`LATC_DIRECT_HI:0] direct_loc = macl_q[`LATC_DIRECT_HI:0];
  wire [LKP_AW-1:0] key_idx = direct_q ?
    direct_loc[LKP_AW-1:0] : hashed[LKP_AW-1:0];
  wire [LKP_AW-1:0] scan_last = {LKP_AW{1'b1}};
  wire [CNT_W-1:0] cnt_inc = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
  wire [LKP_AW-1:0] scan_inc = scan_idx_q + {{(LKP_AW-1){1'b0}}, 1'b1};

  wire [`LATC_ENT_W-1:0] lkp_rdata;
  wire [`LATC_ENT_W-1:0] sta_rdata;
  wire [31:0] rmc_rdata;
  wire in_scan = (st_q == S_SCAN) | (st_q == S_EVAL) | (st_q == S_HOLD);
  wire [LKP_AW-1:0] lkp_addr = in_scan ? scan_idx_q : key_idx;
  wire lkp_we = st_q == S_WR;
  wire ent_hit = lkp_rdata[`LATC_ENT_VALID_BIT];
  wire eval_hit = (st_q == S_EVAL) & ent_hit;
  wire lkp_load = (st_q == S_RDL) | eval_hit;
  wire sta_load = tst_q == T_LD;
  wire sta_we = (tst_q == T_OP) & ~sop_q & ~tsel_q;
  wire rmc_we = (tst_q == T_OP) & ~sop_q & tsel_q;
  wire [STA_AW-1:0] sta_addr = tidx_q[STA_AW-1:0];
  wire [RMC_AW-1:0] rmc_addr = tidx_q[RMC_AW-1:0];

  latc_table_mem #(.AW(LKP_AW), .DW(`LATC_ENT_W)) u_lkp_mem (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .we_in(lkp_we),
    .addr_in(lkp_addr),
    .wdata_in(ent_q),
    .rdata_out(lkp_rdata)
  );

  latc_table_mem #(.AW(STA_AW), .DW(`LATC_ENT_W)) u_sta_mem (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .we_in(sta_we),
    .addr_in(sta_addr),
    .wdata_in(ent_q),
    .rdata_out(sta_rdata)
  );

  latc_table_mem #(.AW(RMC_AW), .DW(32)) u_rmc_mem (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .we_in(rmc_we),
    .addr_in(rmc_addr),
    .wdata_in(ent_q[`LATC_E2_HI:`LATC_E2_LO]),
    .rdata_out(rmc_rdata)
  );

  // Lookup table sequencer
  always @* begin
    st_d = st_q;
    case (st_q)
      S_IDLE: begin
        if (lkp_start) begin
          case (act_w)
            `LATC_ACT_WRITE: st_d = S_WR;
            `LATC_ACT_READ: st_d = S_RD;
            `LATC_ACT_SEARCH: st_d = S_SCAN;
            default: st_d = S_IDLE;
          endcase
        end
      end
      S_WR: st_d = S_IDLE;
      S_RD: st_d = S_RDL;
      S_RDL: st_d = S_IDLE;
      S_SCAN: st_d = S_EVAL;
      S_EVAL: begin
        if (ent_hit) begin
          st_d = S_HOLD;
        end else if (scan_idx_q == scan_last) begin
          st_d = S_IDLE;
        end else begin
          st_d = S_SCAN;
        end
      end
      S_HOLD: begin
        if (top_read) begin
          st_d = (scan_idx_q == scan_last) ? S_IDLE : S_SCAN;
        end
      end
      default: st_d = S_IDLE;
    endcase
  end

  wire lkp_finish = (st_q != S_IDLE) & (st_d == S_IDLE);
  wire search_done = in_scan & (st_d == S_IDLE);

  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      st_q <= S_IDLE;
      rsv31_q <= 1'b0;
      filter_id_q <= `LATC_RST_FILT;
      mach_q <= `LATC_RST_MACH;
      macl_q <= `LATC_RST_WORD;
      go_q <= 1'b0;
      arsv_q <= `LATC_RST_RSV2;
      direct_q <= 1'b0;
      act_q <= `LATC_RST_ACT;
      valid_q <= 1'b0;
      search_end_q <= 1'b0;
      cnt_q <= {CNT_W{1'b0}};
      scan_idx_q <= {LKP_AW{1'b0}};
    end else begin
      st_q <= st_d;
      if (reg_wr_in & hit_ihi) begin
        rsv31_q <= ihi_w[`LATC_RSV31_BIT];
        filter_id_q <= ihi_w[`LATC_FILT_HI:`LATC_FILT_LO];
        mach_q <= ihi_w[`LATC_MACH_HI:`LATC_MACH_LO];
      end
      if (reg_wr_in & hit_ilo) begin
        macl_q <= ilo_w;
      end
      if (wr_actl) begin
        arsv_q <= actl_w[`LATC_ARSV_HI:`LATC_ARSV_LO];
        direct_q <= actl_w[`LATC_DIRECT_BIT];
        act_q <= act_w;
      end
      if (lkp_start & (act_w != `LATC_ACT_NOP)) begin
        go_q <= 1'b1;
      end else if (lkp_finish) begin
        go_q <= 1'b0;
      end
      if (lkp_start & (act_w == `LATC_ACT_SEARCH)) begin
        cnt_q <= {CNT_W{1'b0}};
        scan_idx_q <= {LKP_AW{1'b0}};
      end else begin
        if (eval_hit) begin
          cnt_q <= cnt_inc;
        end
        if (((st_q == S_EVAL) & ~ent_hit) | ((st_q == S_HOLD) & top_read))
        begin
          scan_idx_q <= scan_inc;
        end
      end
      if (eval_hit) begin
        valid_q <= 1'b1;
      end else if (top_read) begin
        valid_q <= 1'b0;
      end
      if (lkp_start) begin
        search_end_q <= 1'b0;
      end else if (search_done) begin
        search_end_q <= 1'b1;
      end
    end
  end

  // Static / reserved multicast sequencer
  always @* begin
    tst_d = tst_q;
    case (tst_q)
      T_IDLE: begin
        if (sta_start) begin
          tst_d = T_OP;
        end
      end
      T_OP: tst_d = sop_q ? T_LD : T_IDLE;
      T_LD: tst_d = T_IDLE;
      default: tst_d = T_IDLE;
    endcase
  end

  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      tst_q <= T_IDLE;
      sgo_q <= 1'b0;
      tidx_q <= `LATC_RST_TIDX;
      srsv_q <= `LATC_RST_RSV5;
      tsel_q <= 1'b0;
      sop_q <= 1'b0;
    end else begin
      tst_q <= tst_d;
      if (wr_sctl) begin
        tidx_q <= sctl_w[`LATC_TIDX_HI:`LATC_TIDX_LO];
        srsv_q <= sctl_w[`LATC_SRSV_HI:`LATC_SRSV_LO];
        tsel_q <= sctl_w[`LATC_TSEL_BIT];
        sop_q <= sctl_w[`LATC_SOP_BIT];
      end
      if (sta_start) begin
        sgo_q <= 1'b1;
      end else if ((tst_q != T_IDLE) & (tst_d == T_IDLE)) begin
        sgo_q <= 1'b0;
      end
    end
  end

  // Shared entry registers; table loads win over software writes
  always @* begin
    ent_d = ent_q;
    if (reg_wr_in & hit_e1) begin
      ent_d[`LATC_E1_HI:`LATC_E1_LO] =
        be_merge(ent_q[`LATC_E1_HI:`LATC_E1_LO], reg_wdata_in, reg_be_in);
    end
    if (reg_wr_in & hit_e2) begin
      ent_d[`LATC_E2_HI:`LATC_E2_LO] =
        be_merge(ent_q[`LATC_E2_HI:`LATC_E2_LO], reg_wdata_in, reg_be_in);
    end
    if (reg_wr_in & hit_e3) begin
      ent_d[`LATC_E3_HI:`LATC_E3_LO] =
        be_merge(ent_q[`LATC_E3_HI:`LATC_E3_LO], reg_wdata_in, reg_be_in);
    end
    if (reg_wr_in & hit_e4) begin
      ent_d[`LATC_E4_HI:`LATC_E4_LO] =
        be_merge(ent_q[`LATC_E4_HI:`LATC_E4_LO], reg_wdata_in, reg_be_in);
    end
    if (lkp_load) begin
      ent_d = lkp_rdata;
    end
    if (sta_load) begin
      if (tsel_q) begin
        ent_d[`LATC_E2_HI:`LATC_E2_LO] = rmc_rdata;
      end else begin
        ent_d = sta_rdata;
      end
    end
  end

  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      ent_q <= `LATC_RST_ENT;
    end else begin
      ent_q <= ent_d;
    end
  end

  // Register read port; unmapped addresses read zero
  always @* begin
    rd_mux = `LATC_RST_WORD;
    if (hit_ihi) begin
      rd_mux = ihi_now;
    end
    if (hit_ilo) begin
      rd_mux = macl_q;
    end
    if (hit_actl) begin
      rd_mux = actl_now;
    end
    if (hit_sctl) begin
      rd_mux = sctl_now;
    end
    if (hit_e1) begin
      rd_mux = ent_q[`LATC_E1_HI:`LATC_E1_LO];
    end
    if (hit_e2) begin
      rd_mux = ent_q[`LATC_E2_HI:`LATC_E2_LO];
    end
    if (hit_e3) begin
      rd_mux = ent_q[`LATC_E3_HI:`LATC_E3_LO];
    end
    if (hit_e4) begin
      rd_mux = ent_q[`LATC_E4_HI:`LATC_E4_LO];
    end
  end

  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      rdata_q <= `LATC_RST_WORD;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd_in;
      if (reg_rd_in) begin
        rdata_q <= rd_mux;
      end
    end
  end

  assign reg_rdata_out = rdata_q;
  assign reg_rvalid_out = rvalid_q;
endmodule // latc_ctrl

// ===== design/latc_regs.vh
`ifndef LATC_REGS_VH
`define LATC_REGS_VH

// Register byte addresses
`define LATC_OFS_IDX_HI 16'h0410
`define LATC_OFS_IDX_LO 16'h0414
`define LATC_OFS_LKP_CTL 16'h0418
`define LATC_OFS_STA_CTL 16'h041c
`define LATC_OFS_ENT1 16'h0420
`define LATC_OFS_ENT2 16'h0424
`define LATC_OFS_ENT3 16'h0428
`define LATC_OFS_ENT4 16'h042c

// Reset values
`define LATC_RST_WORD 32'h00000000
`define LATC_RST_ENT 128'h0
`define LATC_RST_FILT 7'h00
`define LATC_RST_MACH 16'h0000
`define LATC_RST_ACT 2'h0
`define LATC_RST_TIDX 6'h00
`define LATC_RST_RSV2 2'h0
`define LATC_RST_RSV5 5'h00

// Index high word fields, plus the top bit of the direct index taken from the index low word
`define LATC_RSV31_BIT 31
`define LATC_FILT_HI 22
`define LATC_FILT_LO 16
`define LATC_MACH_HI 15
`define LATC_MACH_LO 0
`define LATC_DIRECT_HI 11

// Lookup access control fields
`define LATC_CNT_HI 29
`define LATC_CNT_LO 16
`define LATC_GO_BIT 7
`define LATC_VALID_BIT 6
`define LATC_VES_BIT 5
`define LATC_ARSV_HI 4
`define LATC_ARSV_LO 3
`define LATC_DIRECT_BIT 2
`define LATC_ACT_HI 1
`define LATC_ACT_LO 0

// Lookup actions
`define LATC_ACT_NOP 2'h0
`define LATC_ACT_WRITE 2'h1
`define LATC_ACT_READ 2'h2
`define LATC_ACT_SEARCH 2'h3

// Static / reserved multicast control fields
`define LATC_TIDX_HI 21
`define LATC_TIDX_LO 16
`define LATC_SRSV_HI 6
`define LATC_SRSV_LO 2
`define LATC_TSEL_BIT 1
`define LATC_SOP_BIT 0

// Entry layout: entry 1 word is bits 127:96, entry 4 word bits 31:0
`define LATC_ENT_W 128
`define LATC_ENT_VALID_BIT 127
`define LATC_E1_HI 127
`define LATC_E1_LO 96
`define LATC_E2_HI 95
`define LATC_E2_LO 64
`define LATC_E3_HI 63
`define LATC_E3_LO 32
`define LATC_E4_HI 31
`define LATC_E4_LO 0

// Byte lane holding the top byte of entry 4
`define LATC_LANE_TOP 3
`define LATC_LANE_CTL 0
`define LATC_LANE_W 8
`define LATC_LANES 4

// Hash geometry
`define LATC_HASH_W 12
`define LATC_FILT_PAD 5'h00

`endif

// ===== design/latc_table_mem.v
module latc_table_mem #(
  parameter AW = 4,
  parameter DW = 128
) (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire we_in,
  input wire [AW-1:0] addr_in,
  input wire [DW-1:0] wdata_in,
  output wire [DW-1:0] rdata_out
);
  localparam DEPTH = 1 << AW;

  reg [DW-1:0] mem [0:DEPTH-1];
  reg [DEPTH-1:0] written_q;
  reg [DW-1:0] rdata_q;
  reg rvld_q;

  // Never-written locations read as zero
  always @(posedge core_clk_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
    rdata_q <= we_in ? wdata_in : mem[addr_in];
  end

  always @(posedge core_clk_in) begin
    if (!rst_n_in) begin
      written_q <= {DEPTH{1'b0}};
      rvld_q <= 1'b0;
    end else begin
      if (we_in) begin
        written_q[addr_in] <= 1'b1;
      end
      rvld_q <= written_q[addr_in] | we_in;
    end
  end

  assign rdata_out = rvld_q ? rdata_q : {DW{1'b0}};
endmodule // latc_table_mem

// ===== dv/latc_ctrl_properties.sv
module latc_ctrl_properties (
  input wire core_clk_in,
  input wire rst_n_in,
  input wire [15:0] reg_addr_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [3:0] reg_be_in,
  input wire [31:0] reg_wdata_in,
  input wire [31:0] reg_rdata_out,
  input wire reg_rvalid_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence rd_ctl;
    reg_rd_in && reg_addr_in == 16'h0418;
  endsequence
  sequence rd_sta;
    reg_rd_in && reg_addr_in == 16'h041c;
  endsequence
  sequence go_lkp_wr;
    reg_wr_in && reg_addr_in == 16'h0418 && reg_be_in[0] &&
      reg_wdata_in[7] && reg_wdata_in[1:0] == 2'h1;
  endsequence
  sequence go_sta_wr;
    reg_wr_in && reg_addr_in == 16'h041c && reg_be_in[0] &&
      reg_wdata_in[7] && !reg_wdata_in[0];
  endsequence
  a_rvalid_after_read: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("rvalid missing after read");
  a_rvalid_only_read: assert property (!reg_rd_in |=> !reg_rvalid_out)
    else $error("rvalid without read");
  a_rdata_holds: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
    else $error("read data moved without read");
  a_ctl_reserved_zero: assert property (rd_ctl |=>
    reg_rdata_out[31:30] == 2'h0 && reg_rdata_out[15:8] == 8'h00)
    else $error("control reserved bits not zero");
  a_sta_reserved_zero: assert property (rd_sta |=>
    reg_rdata_out[31:22] == 10'h000 && reg_rdata_out[15:8] == 8'h00)
    else $error("static control reserved bits not zero");
  a_idx_reserved_zero: assert property (reg_rd_in &&
    reg_addr_in == 16'h0410 |=> reg_rdata_out[30:23] == 8'h00)
    else $error("index reserved bits not zero");
  a_ready_sets_flag: assert property (rd_ctl |=>
    !reg_rdata_out[6] || reg_rdata_out[5])
    else $error("bit 5 low while entry ready");
  a_ready_in_search: assert property (rd_ctl |=>
    !reg_rdata_out[6] || reg_rdata_out[7])
    else $error("entry ready outside search");
  a_lkp_go_clears: assert property (go_lkp_wr ##2 rd_ctl |=>
    !reg_rdata_out[7])
    else $error("lookup write not finished in time");
  a_sta_go_clears: assert property (go_sta_wr ##2 rd_sta |=>
    !reg_rdata_out[7])
    else $error("static write not finished in time");
endmodule // latc_ctrl_properties

// ===== dv/test_lookup_table_access_ctrl.sv
module test_lookup_table_access_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in = 1'h0;
  logic rst_n_in = 1'h0;
  logic [15:0] reg_addr_in = 16'h0000;
  logic reg_wr_in = 1'h0;
  logic reg_rd_in = 1'h0;
  logic [3:0] reg_be_in = 4'h0;
  logic [31:0] reg_wdata_in = 32'h00000000;
  wire [31:0] reg_rdata_out;
  wire reg_rvalid_out;
  int n_mismatch = 0;
  int tests_run = 0;
  logic [31:0] d;
  logic [3:0] h;
  logic [6:0] filter_id = 7'h2a;
  logic [47:0] mac = 48'h123456789abc;
  always #5 core_clk_in = ~core_clk_in;
  latc_ctrl #(.LKP_AW(4), .STA_AW(4), .RMC_AW(6), .CNT_W(14)) latc_ctrl_i (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_be_in(reg_be_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_rdata_out(reg_rdata_out),
    .reg_rvalid_out(reg_rvalid_out)
  );
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_be_in <= 4'hf;
    reg_wr_in <= 1'h1;
    @(posedge core_clk_in);
    reg_wr_in <= 1'h0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [3:0] be);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_be_in <= be;
    reg_rd_in <= 1'h1;
    @(posedge core_clk_in);
    reg_rd_in <= 1'h0;
    #1;
    chk({31'h0, reg_rvalid_out}, 32'h1, "no read answer");
    d = reg_rdata_out;
  endtask
  task automatic rchk(input logic [15:0] a, input logic [31:0] e);
    rd(a, 4'h0);
    chk(d, e, "read value");
  endtask
  task automatic poll(input logic [15:0] a);
    for (int i = 0; i < 20; i++) begin
      rd(a, 4'h0);
      if (!d[7]) break;
    end
    chk({31'h0, d[7]}, 32'h0, "start bit stuck");
  endtask
  task automatic went(input logic [31:0] a, b, c, e);
    wr(16'h0420, a);
    wr(16'h0424, b);
    wr(16'h0428, c);
    wr(16'h042c, e);
  endtask
  task automatic cent(input logic [31:0] a, b, c, e);
    rchk(16'h0420, a);
    rchk(16'h0424, b);
    rchk(16'h0428, c);
    rchk(16'h042c, e);
  endtask
  task automatic t_regs;
    cent(32'h0, 32'h0, 32'h0, 32'h0);
    rchk(16'h0418, 32'h0);
    wr(16'h0410, 32'hffffffff);
    rchk(16'h0410, 32'h807fffff);
    wr(16'h0418, 32'hffffff7c);
    rchk(16'h0418, 32'h0000001c);
    wr(16'h041c, 32'hffffff7f);
    rchk(16'h041c, 32'h003f007f);
    wr(16'h041c, 32'h0);
    wr(16'h0500, 32'hffffffff);
    rchk(16'h0500, 32'h0);
    $display("test regs done");
  endtask
  task automatic t_lookup;
    wr(16'h0410, {9'h0, filter_id, mac[47:32]});
    wr(16'h0414, mac[31:0]);
    went(32'h800000a1, 32'h11112222, 32'h33334444, 32'h55556666);
    wr(16'h0418, 32'h81);
    poll(16'h0418);
    went(32'h0, 32'h0, 32'h0, 32'h0);
    wr(16'h0418, 32'h82);
    poll(16'h0418);
    cent(32'h800000a1, 32'h11112222, 32'h33334444, 32'h55556666);
    h = mac[3:0] ^ mac[15:12] ^ mac[27:24] ^ mac[39:36] ^ filter_id[3:0];
    went(32'h0, 32'h0, 32'h0, 32'h0);
    wr(16'h0414, {20'habcde, 8'h00, h});
    wr(16'h0418, 32'h86);
    poll(16'h0418);
    rchk(16'h0420, 32'h800000a1);
    went(32'h800000b2, 32'h1, 32'h2, 32'h3);
    wr(16'h0414, {28'h0, h ^ 4'h1});
    wr(16'h0418, 32'h85);
    poll(16'h0418);
    $display("test lookup done");
  endtask
  task automatic t_search;
    int found;
    found = 0;
    wr(16'h0418, 32'h83);
    for (int i = 0; i < 60; i++) begin
      rd(16'h0418, 4'h0);
      if (!d[7]) break;
      if (d[6]) begin
        chk({31'h0, d[5]}, 32'h1, "bit 5 low with entry");
        rd(16'h0420, 4'h0);
        chk({31'h0, d[31]}, 32'h1, "entry not loaded");
        rd(16'h042c, 4'h8);
        rd(16'h0418, 4'h0);
        chk({31'h0, d[6]}, 32'h0, "ready not cleared");
        found++;
      end
    end
    chk(d & 32'h3fff00e0, {2'h0, 14'h2, 8'h0, 8'h20}, "search end");
    chk(found, 32'h2, "entries seen");
    wr(16'h0418, 32'h80);
    rd(16'h0418, 4'h0);
    chk({31'h0, d[7]}, 32'h0, "no-op start");
    $display("test search done");
  endtask
  task automatic t_static;
    went(32'ha0a00001, 32'hb0b00002, 32'hc0c00003, 32'hd0d00004);
    wr(16'h041c, 32'h00030080);
    poll(16'h041c);
    went(32'h0, 32'h0, 32'h0, 32'h0);
    wr(16'h041c, 32'h00130081);
    poll(16'h041c);
    cent(32'ha0a00001, 32'hb0b00002, 32'hc0c00003, 32'hd0d00004);
    wr(16'h0424, 32'h00000c5c);
    wr(16'h041c, 32'h00250082);
    poll(16'h041c);
    went(32'h00007777, 32'h0, 32'h0, 32'h0);
    wr(16'h041c, 32'h00250083);
    poll(16'h041c);
    cent(32'h00007777, 32'h00000c5c, 32'h0, 32'h0);
    wr(16'h041c, 32'h00050083);
    poll(16'h041c);
    rchk(16'h0424, 32'h0);
    $display("test static done");
  endtask
  task automatic t_reset;
    @(posedge core_clk_in);
    rst_n_in <= 1'h0;
    repeat (2) @(posedge core_clk_in);
    rst_n_in <= 1'h1;
    cent(32'h0, 32'h0, 32'h0, 32'h0);
    rchk(16'h041c, 32'h0);
    wr(16'h041c, 32'h00030081);
    poll(16'h041c);
    cent(32'h0, 32'h0, 32'h0, 32'h0);
    $display("test reset done");
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge core_clk_in);
    rst_n_in <= 1'h1;
    t_regs();
    t_lookup();
    t_search();
    t_static();
    t_reset();
    print_verdict();
  end
endmodule // test_lookup_table_access_ctrl
bind latc_ctrl latc_ctrl_properties latc_ctrl_properties_i (
  .core_clk_in(core_clk_in),
  .rst_n_in(rst_n_in),
  .reg_addr_in(reg_addr_in),
  .reg_wr_in(reg_wr_in),
  .reg_rd_in(reg_rd_in),
  .reg_be_in(reg_be_in),
  .reg_wdata_in(reg_wdata_in),
  .reg_rdata_out(reg_rdata_out),
  .reg_rvalid_out(reg_rvalid_out)
);
